//--- verilog/pic_pkg.sv
// Purpose: shared constants and types of the priority interrupt controller
// Assumes: 8-bit register port, eight maskable sources
// Notes: source 0 ranks highest in the default order
package pic_pkg;
	// ************************************************
	// sizes
	// ************************************************
	localparam int NUM_SRC = 8;
	localparam int LVL_W = 3;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [3:0] ADDR_SYSCTL = 4'h0;
	localparam logic [3:0] ADDR_ENABLE = 4'h1;
	localparam logic [3:0] ADDR_FLAGS = 4'h2;
	localparam logic [3:0] ADDR_PRIO0 = 4'h3;
	localparam logic [3:0] ADDR_PRIO3 = 4'h6;
	localparam logic [3:0] ADDR_COND_CODE = 4'h7;
	localparam logic [3:0] ADDR_EXT_STATUS = 4'h8;
	localparam logic [3:0] ADDR_VECTOR = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'hA;

	// ************************************************
	// field positions and masks
	// ************************************************
	localparam int SYSCTL_MODE_HI_BIT = 5;
	localparam int COND_I_BIT = 7;
	localparam int EXT_T_BIT = 7;
	localparam logic [7:0] PRIO_MASK = 8'h77;

	// ************************************************
	// reset values and codes
	// ************************************************
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_PRIO = 8'h77;
	localparam logic RST_COND_I = 1'b1;
	localparam logic [2:0] RST_MASK_LVL = 3'h7;
	localparam logic [2:0] NMI_LEVEL = 3'h7;
	localparam logic [7:0] VEC_NMI = 8'h07;
	localparam logic [7:0] VEC_BASE = 8'h40;
	localparam logic [1:0] BLOCK_STATES = 2'h3;

	typedef enum logic [2:0] {
		PIC_IDLE = 3'b000,
		PIC_WAIT = 3'b001,
		PIC_PUSH_PC = 3'b010,
		PIC_PUSH_COND = 3'b011,
		PIC_PUSH_EXT = 3'b100,
		PIC_FETCH = 3'b101
	} pic_state_t;
endpackage

//--- verilog/pic_sel_if.sv
`timescale 1ns/1ps
// Purpose: carries requests and levels to the resolver and its winner back
// Assumes: one clock domain, purely combinational path
// Notes: none
interface pic_sel_if;
	logic [7:0] req;
	logic [23:0] lvl;
	logic win_valid;
	logic [2:0] win_idx;
	logic [2:0] win_lvl;
	modport ctl (output req, output lvl, input win_valid, input win_idx, input win_lvl);
	modport res (input req, input lvl, output win_valid, output win_idx, output win_lvl);
endinterface

//--- verilog/pic_flag_cell.sv
`timescale 1ns/1ps
// Purpose: one sticky source flag with deferred software clear
// Assumes: insn_done pulses at the end of each instruction
// Notes: a new event wins over any clear, including a pending software clear that takes effect at insn_done
module pic_flag_cell
	import pic_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic evt,
	input wire logic en,
	input wire logic sw_clr,
	input wire logic acc_clr,
	input wire logic insn_done,
	output logic flag
);
	typedef struct packed {
		logic flag;
		logic clr_hold;
	} pic_cell_t;

	pic_cell_t cell_reg;
	pic_cell_t cell_next;

	always_comb begin
		cell_next = cell_reg;
		if (sw_clr) begin
			cell_next.clr_hold = 1'b1;
		end
		if (insn_done && (cell_reg.clr_hold || sw_clr)) begin
			cell_next.flag = 1'b0;
			cell_next.clr_hold = 1'b0;
		end
		if (acc_clr) begin
			cell_next.flag = 1'b0;
		end
		if (evt && en) begin
			cell_next.flag = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cell_reg <= '0;
		end else begin
			cell_reg <= cell_next;
		end
	end

	assign flag = cell_reg.flag;
endmodule // pic_flag_cell

//--- verilog/pic_prio_sel.sv
`timescale 1ns/1ps
// Purpose: picks the highest level request, ties by default order
// Assumes: all levels zero gives plain default order
// Notes: lower index ranks higher
module pic_prio_sel
	import pic_pkg::*;
(
	pic_sel_if.res sel
);
	always_comb begin
		sel.win_valid = 1'b0;
		sel.win_idx = 3'h0;
		sel.win_lvl = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (sel.req[i] && (!sel.win_valid || sel.lvl[i*3 +: 3] >= sel.win_lvl)) begin
				sel.win_valid = 1'b1;
				sel.win_idx = 3'(i);
				sel.win_lvl = sel.lvl[i*3 +: 3];
			end
		end
	end
endmodule // pic_prio_sel

//--- verilog/pic_top.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Purpose: priority interrupt controller with cpu acceptance sequence
// Assumes: cpu pulses insn_done at each instruction end
// Notes: vector address is vector number times four
//
// Overview of operation
// - nmi accepted except in reset, hardware standby, or the three states after a mask register write.
// - each maskable source has an enable; enable 1 raises, 0 blocks.
// - mode select 00 is mode 0, 10 is mode 2; low bit never set.
// - mode 0 with mask bit 1 accepts only nmi, others stay pending.
// - mode 0 accepts the top request in fixed default order.
// - mode 2 picks the highest programmed of eight levels.
// - mode 2 equal levels resolved by fixed default order.
// - mode 2 accepts only levels strictly above the mask level.
// - mode 2 ignores mask bit for gating but sets it on accept.
// - exception processing starts after current instruction ends.
// - mode 0 stacks return pc and condition codes.
// - mode 0 sets mask bit after stacking.
// - mode 2 stacks pc, condition codes and extended status.
// - mode 2 clears trace, loads mask level; nmi loads seven.
// - vector number given; handler address fetched and jumped to.
// - acceptance refused three states after a mask register write.
// - clearing enable or flag takes effect after the instruction.
module pic_top
	import pic_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hw_standby,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic nmi_in,
	input wire logic [7:0] src_evt,
	input wire logic insn_done,
	input wire logic [15:0] cur_pc,
	output logic irq_req,
	output logic [7:0] vec_num,
	output logic push_valid,
	output logic [15:0] push_data,
	output logic fetch_req,
	output logic [15:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic [15:0] fetch_data,
	output logic jump_valid,
	output logic [15:0] jump_pc
);
	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic [7:0] rdata;
		logic mode2;
		logic [7:0] en;
		logic [7:0] en_hold;
		logic [3:0][7:0] prio;
		logic mask_bit;
		logic trace_bit;
		logic [2:0] mask_lvl;
		logic [1:0] block_cnt;
		logic nmi_flag;
		pic_state_t st;
		logic [2:0] acc_lvl;
		logic [7:0] vec;
		logic [15:0] ret_pc;
		logic irq_req;
		logic push_valid;
		logic [15:0] push_data;
		logic fetch_req;
		logic [15:0] fetch_addr;
		logic jump_valid;
		logic [15:0] jump_pc;
	} pic_top_t;

	pic_top_t s_reg;
	pic_top_t s_next;
	logic [7:0] flags;
	logic [7:0] sw_clr;
	logic [7:0] acc_clr;
	logic [7:0] en_live;
	logic [7:0] evt_gated;
	logic mask_ok;
	pic_sel_if sel();

	// ************************************************
	// source flags and resolver
	// ************************************************
	assign en_live = s_reg.en | s_reg.en_hold;
	assign evt_gated = hw_standby ? 8'h00 : src_evt;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			pic_flag_cell u_cell (
				.clk(clk),
				.reset(reset),
				.evt(evt_gated[g]),
				.en(en_live[g]),
				.sw_clr(sw_clr[g]),
				.acc_clr(acc_clr[g]),
				.insn_done(insn_done),
				.flag(flags[g])
			);
		end
	endgenerate

	always_comb begin
		sel.req = flags & en_live;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (!s_reg.mode2) begin
				sel.lvl[i*3 +: 3] = 3'h0;
			end else if (i % 2 == 0) begin
				sel.lvl[i*3 +: 3] = s_reg.prio[i/2][6:4];
			end else begin
				sel.lvl[i*3 +: 3] = s_reg.prio[i/2][2:0];
			end
		end
	end

	pic_prio_sel u_sel (
		.sel(sel)
	);

	assign mask_ok = sel.win_valid &&
		(s_reg.mode2 ? (sel.win_lvl > s_reg.mask_lvl) : !s_reg.mask_bit);

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		s_next = s_reg;
		sw_clr = 8'h00;
		acc_clr = 8'h00;
		s_next.push_valid = 1'b0;
		s_next.jump_valid = 1'b0;
		s_next.rdata = 8'h00;
		if (s_reg.block_cnt != 2'h0) begin
			s_next.block_cnt = s_reg.block_cnt - 2'h1;
		end
		if (insn_done) begin
			s_next.en_hold = 8'h00;
		end
		if (wr) begin
			if (addr == ADDR_SYSCTL) begin
				s_next.mode2 = wdata[SYSCTL_MODE_HI_BIT];
			end else if (addr == ADDR_ENABLE) begin
				s_next.en_hold = s_next.en_hold | (s_reg.en & ~wdata);
				s_next.en = wdata;
			end else if (addr == ADDR_FLAGS) begin
				sw_clr = wdata;
			end else if (addr >= ADDR_PRIO0 && addr <= ADDR_PRIO3) begin
				s_next.prio[2'(addr - ADDR_PRIO0)] = wdata & PRIO_MASK;
			end else if (addr == ADDR_COND_CODE) begin
				s_next.mask_bit = wdata[COND_I_BIT];
				s_next.block_cnt = BLOCK_STATES;
			end else if (addr == ADDR_EXT_STATUS) begin
				s_next.trace_bit = wdata[EXT_T_BIT];
				s_next.mask_lvl = wdata[2:0];
				s_next.block_cnt = BLOCK_STATES;
			end
		end
		if (rd) begin
			if (addr == ADDR_SYSCTL) begin
				s_next.rdata = {2'b00, s_reg.mode2, 5'h00};
			end else if (addr == ADDR_ENABLE) begin
				s_next.rdata = s_reg.en;
			end else if (addr == ADDR_FLAGS) begin
				s_next.rdata = flags;
			end else if (addr >= ADDR_PRIO0 && addr <= ADDR_PRIO3) begin
				s_next.rdata = s_reg.prio[2'(addr - ADDR_PRIO0)];
			end else if (addr == ADDR_COND_CODE) begin
				s_next.rdata = {s_reg.mask_bit, 7'h00};
			end else if (addr == ADDR_EXT_STATUS) begin
				s_next.rdata = {s_reg.trace_bit, 4'h0, s_reg.mask_lvl};
			end else if (addr == ADDR_VECTOR) begin
				s_next.rdata = s_reg.vec;
			end else if (addr == ADDR_STATUS) begin
				s_next.rdata = {s_reg.nmi_flag, s_reg.irq_req, 3'h0, s_reg.st};
			end
		end

		// ************************************************
		// acceptance and exception sequence
		// ************************************************
		case (s_reg.st)
			PIC_IDLE: begin
				if (s_reg.block_cnt == 2'h0) begin
					if (s_reg.nmi_flag) begin
						s_next.nmi_flag = 1'b0;
						s_next.acc_lvl = NMI_LEVEL;
						s_next.vec = VEC_NMI;
						s_next.irq_req = 1'b1;
						s_next.st = PIC_WAIT;
						if (s_reg.mode2) begin
							s_next.mask_bit = 1'b1;
						end
					end else if (mask_ok) begin
						acc_clr[sel.win_idx] = 1'b1;
						s_next.acc_lvl = sel.win_lvl;
						s_next.vec = VEC_BASE + {5'h00, sel.win_idx};
						s_next.irq_req = 1'b1;
						s_next.st = PIC_WAIT;
						if (s_reg.mode2) begin
							s_next.mask_bit = 1'b1;
						end
					end
				end
			end
			PIC_WAIT: begin
				if (insn_done) begin
					s_next.ret_pc = cur_pc;
					s_next.irq_req = 1'b0;
					s_next.st = PIC_PUSH_PC;
				end
			end
			PIC_PUSH_PC: begin
				s_next.push_valid = 1'b1;
				s_next.push_data = s_reg.ret_pc;
				s_next.st = PIC_PUSH_COND;
			end
			PIC_PUSH_COND: begin
				s_next.push_valid = 1'b1;
				s_next.push_data = {8'h00, s_reg.mask_bit, 7'h00};
				if (s_reg.mode2) begin
					s_next.st = PIC_PUSH_EXT;
				end else begin
					s_next.mask_bit = 1'b1;
					s_next.fetch_req = 1'b1;
					s_next.fetch_addr = {6'h00, s_reg.vec, 2'b00};
					s_next.st = PIC_FETCH;
				end
			end
			PIC_PUSH_EXT: begin
				s_next.push_valid = 1'b1;
				s_next.push_data = {8'h00, s_reg.trace_bit, 4'h0, s_reg.mask_lvl};
				s_next.trace_bit = 1'b0;
				s_next.mask_lvl = s_reg.acc_lvl;
				s_next.fetch_req = 1'b1;
				s_next.fetch_addr = {6'h00, s_reg.vec, 2'b00};
				s_next.st = PIC_FETCH;
			end
			PIC_FETCH: begin
				if (fetch_ack) begin
					s_next.fetch_req = 1'b0;
					s_next.jump_valid = 1'b1;
					s_next.jump_pc = fetch_data;
					s_next.st = PIC_IDLE;
				end
			end
			default: begin
				s_next.st = PIC_IDLE;
			end
		endcase

		if (nmi_in) begin
			s_next.nmi_flag = 1'b1;
		end
		if (hw_standby) begin
			s_next.nmi_flag = 1'b0;
			s_next.irq_req = 1'b0;
			s_next.fetch_req = 1'b0;
			s_next.push_valid = 1'b0;
			s_next.jump_valid = 1'b0;
			s_next.st = PIC_IDLE;
			acc_clr = 8'h00;
		end
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.en <= RST_ENABLE;
			s_reg.prio <= {4{RST_PRIO}};
			s_reg.mask_bit <= RST_COND_I;
			s_reg.mask_lvl <= RST_MASK_LVL;
			s_reg.st <= PIC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata = s_reg.rdata;
	assign irq_req = s_reg.irq_req;
	assign vec_num = s_reg.vec;
	assign push_valid = s_reg.push_valid;
	assign push_data = s_reg.push_data;
	assign fetch_req = s_reg.fetch_req;
	assign fetch_addr = s_reg.fetch_addr;
	assign jump_valid = s_reg.jump_valid;
	assign jump_pc = s_reg.jump_pc;
endmodule // pic_top

//--- bench/pic_cpu_model.sv
// Purpose: cpu side responder for vector fetches
// Assumes: fetch_req stays up until fetch_ack
// Notes: wait_cycles sets the answer delay
`timescale 1ns/1ps
module pic_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic [3:0] wait_cycles,
	output logic fetch_ack,
	output logic [15:0] fetch_data
);
	logic [3:0] cnt_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_reg <= 4'h0;
			fetch_ack <= 1'b0;
			fetch_data <= 16'h0000;
		end else if (fetch_req && !fetch_ack && cnt_reg >= wait_cycles) begin
			fetch_ack <= 1'b1;
			fetch_data <= fetch_addr + 16'h1000;
		end else begin
			fetch_ack <= 1'b0;
			fetch_data <= ~fetch_data;
			cnt_reg <= (fetch_req && !fetch_ack) ? cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule // pic_cpu_model

//--- bench/pic_assertions.sv
// Purpose: port checks of pic_top
// Assumes: one clock, sync reset
// Notes: bound after the module
`timescale 1ns/1ps
module pic_assertions
	import pic_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hw_standby,
	input wire logic [3:0] addr,
	input wire logic wr,
	input wire logic insn_done,
	input wire logic [15:0] cur_pc,
	input wire logic irq_req,
	input wire logic [7:0] vec_num,
	input wire logic push_valid,
	input wire logic [15:0] push_data,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic [15:0] fetch_data,
	input wire logic jump_valid,
	input wire logic [15:0] jump_pc
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_FETCH_ADDR: assert property (fetch_req |-> fetch_addr == {6'h00, vec_num, 2'b00})
		else $error("fetch address wrong");
	AST_JUMP: assert property (fetch_req && fetch_ack && !hw_standby |=>
		jump_valid && !fetch_req && jump_pc == $past(fetch_data))
		else $error("jump after fetch wrong");
	AST_FETCH_HOLD: assert property (fetch_req && !fetch_ack && !hw_standby |=>
		fetch_req && $stable(fetch_addr))
		else $error("fetch request dropped");
	AST_STANDBY: assert property (hw_standby |=> !irq_req && !fetch_req)
		else $error("request in standby");
	AST_IRQ_HOLD: assert property (irq_req && !insn_done && !hw_standby |=> irq_req)
		else $error("request left before insn end");
	AST_STACK_PC: assert property (irq_req && insn_done && !hw_standby |=>
		!irq_req ##1 (push_valid && push_data == $past(cur_pc, 2)))
		else $error("return pc not stacked");
	AST_MASK_BLOCK: assert property (wr &&
		(addr == ADDR_COND_CODE || addr == ADDR_EXT_STATUS) |=> ##1 !$rose(irq_req) [*3])
		else $error("accept inside block window");
	AST_VEC_RANGE: assert property ($rose(irq_req) |->
		vec_num == VEC_NMI || vec_num[7:3] == VEC_BASE[7:3])
		else $error("vector number out of range");
	COV_JUMP: cover property (jump_valid);
	COV_NMI: cover property (irq_req && vec_num == VEC_NMI);
	COV_PUSH3: cover property (push_valid [*3]);
endmodule // pic_assertions

bind pic_top pic_assertions chk_i (.clk, .reset, .hw_standby, .addr, .wr, .insn_done,
	.cur_pc, .irq_req, .vec_num, .push_valid, .push_data, .fetch_req, .fetch_addr,
	.fetch_ack, .fetch_data, .jump_valid, .jump_pc);

//--- bench/pic_top_test.sv
// Purpose: self-checking bench of pic_top
// Assumes: cpu model answers vector fetches
// Notes: bench drives insn_done and cur_pc
`timescale 1ns/1ps
module pic_top_test
	import pic_pkg::*;
;
	logic clk = 1'b0, reset = 1'b1, hw_standby = 1'b0, wr = 1'b0, rd = 1'b0;
	logic nmi_in = 1'b0, insn_done = 1'b0, fetch_ack, jump_valid, irq_req, push_valid, fetch_req;
	logic [3:0] addr = 4'h0, wait_cycles = 4'h0;
	logic [7:0] wdata = 8'h00, src_evt = 8'h00, rdata, vec_num;
	logic [15:0] cur_pc = 16'h0000, push_data, fetch_addr, fetch_data, jump_pc;
	int fails = 0, total_checks = 0, cycles = 0;
	pic_top dut (.clk, .reset, .hw_standby, .addr, .wdata, .wr, .rd, .rdata, .nmi_in, .src_evt,
		.insn_done, .cur_pc, .irq_req, .vec_num, .push_valid, .push_data, .fetch_req,
		.fetch_addr, .fetch_ack, .fetch_data, .jump_valid, .jump_pc);
	pic_cpu_model cpu (.clk, .reset, .fetch_req, .fetch_addr, .wait_cycles, .fetch_ack,
		.fetch_data);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({8'h00, rdata & m}, {8'h00, e});
	endtask
	task automatic evt(input logic n, input logic [7:0] s);
		@(posedge clk);
		nmi_in <= n;
		src_evt <= s;
		@(posedge clk);
		nmi_in <= 1'b0;
		src_evt <= 8'h00;
	endtask
	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge clk);
			#1;
			chk({15'h0000, irq_req}, 16'h0000);
		end
	endtask
	task automatic service(input logic [7:0] v, input int np, input logic [15:0] pc,
		input logic [15:0] w1, input logic [15:0] w2);
		int n;
		int k;
		n = 0;
		k = 0;
		#1;
		while (irq_req !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({15'h0000, irq_req}, 16'h0001);
		chk({8'h00, vec_num}, {8'h00, v});
		@(posedge clk);
		insn_done <= 1'b1;
		cur_pc <= pc;
		@(posedge clk);
		insn_done <= 1'b0;
		n = 0;
		while (jump_valid !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
			if (push_valid === 1'b1) begin
				if (k == 0) chk(push_data, pc);
				if (k == 1) chk(push_data, w1);
				if (k == 2) chk(push_data, w2);
				k++;
			end
		end
		chk(k[15:0], np[15:0]);
		chk(jump_pc, {6'h00, v, 2'b00} + 16'h1000);
	endtask
	task automatic t_reset();
		rreg(ADDR_SYSCTL, 8'hFF, 8'h00);
		rreg(ADDR_ENABLE, 8'hFF, RST_ENABLE);
		rreg(ADDR_PRIO0, 8'hFF, RST_PRIO);
		rreg(ADDR_COND_CODE, 8'h80, 8'h80);
		rreg(ADDR_EXT_STATUS, 8'h87, 8'h07);
		$display("t_reset done");
	endtask
	task automatic t_mode0();
		wreg(ADDR_ENABLE, 8'hFD);
		evt(1'b0, 8'h26);
		quiet(8);
		wreg(ADDR_COND_CODE, 8'h00);
		service(VEC_BASE + 8'h02, 2, 16'h1234, 16'h0000, 16'h0000);
		rreg(ADDR_COND_CODE, 8'h80, 8'h80);
		quiet(8);
		evt(1'b1, 8'h00);
		service(VEC_NMI, 2, 16'h2468, 16'h0080, 16'h0000);
		wreg(ADDR_COND_CODE, 8'h00);
		service(VEC_BASE + 8'h05, 2, 16'h0ACE, 16'h0000, 16'h0000);
		wreg(ADDR_COND_CODE, 8'h00);
		quiet(10);
		$display("t_mode0 done");
	endtask
	task automatic t_mode2();
		wreg(ADDR_SYSCTL, 8'h20);
		rreg(ADDR_SYSCTL, 8'hFF, 8'h20);
		wreg(ADDR_PRIO0 + 4'h1, 8'h05);
		wreg(ADDR_PRIO0 + 4'h2, 8'h35);
		wreg(ADDR_PRIO3, 8'h60);
		wreg(ADDR_ENABLE, 8'hFF);
		wreg(ADDR_EXT_STATUS, 8'h83);
		evt(1'b0, 8'h78);
		service(VEC_BASE + 8'h06, 3, 16'h3000, 16'h0080, 16'h0083);
		rreg(ADDR_EXT_STATUS, 8'h87, 8'h06);
		rreg(ADDR_COND_CODE, 8'h80, 8'h80);
		quiet(8);
		wreg(ADDR_EXT_STATUS, 8'h04);
		service(VEC_BASE + 8'h03, 3, 16'h3100, 16'h0080, 16'h0004);
		quiet(8);
		evt(1'b1, 8'h00);
		service(VEC_NMI, 3, 16'h3200, 16'h0080, 16'h0005);
		rreg(ADDR_EXT_STATUS, 8'h87, 8'h07);
		wreg(ADDR_EXT_STATUS, 8'h04);
		service(VEC_BASE + 8'h05, 3, 16'h3300, 16'h0080, 16'h0004);
		$display("t_mode2 done");
	endtask
	task automatic t_clear();
		rreg(ADDR_FLAGS, 8'hFF, 8'h10);
		wreg(ADDR_FLAGS, 8'h10);
		rreg(ADDR_FLAGS, 8'hFF, 8'h10);
		@(posedge clk);
		insn_done <= 1'b1;
		@(posedge clk);
		insn_done <= 1'b0;
		rreg(ADDR_FLAGS, 8'hFF, 8'h00);
		wreg(ADDR_EXT_STATUS, 8'h04);
		wreg(ADDR_ENABLE, 8'hDF);
		evt(1'b0, 8'h20);
		service(VEC_BASE + 8'h05, 3, 16'h3400, 16'h0080, 16'h0004);
		rreg(ADDR_VECTOR, 8'hFF, VEC_BASE + 8'h05);
		rreg(ADDR_STATUS, 8'hFF, 8'h00);
		evt(1'b0, 8'h20);
		rreg(ADDR_FLAGS, 8'h20, 8'h00);
		$display("t_clear done");
	endtask
	task automatic t_standby();
		@(posedge clk);
		hw_standby <= 1'b1;
		evt(1'b1, 8'h00);
		quiet(6);
		@(posedge clk);
		hw_standby <= 1'b0;
		quiet(6);
		evt(1'b1, 8'h00);
		service(VEC_NMI, 3, 16'h3500, 16'h0080, 16'h0005);
		$display("t_standby done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_mode0();
		@(posedge clk);
		wait_cycles <= 4'h5;
		t_mode2();
		t_clear();
		t_standby();
		close_out();
	end
endmodule // pic_top_test
